// ==== src/drcf_top.sv ====
// extended diagnostic record for counter and frequency modes, with register port
//
// Functional notes
// - counter bytes 12 to 15 per counter; bit 0 lost gate-closed interrupt
// - counter byte bit 2 flags lost gate-opened interrupt
// - counter byte bit 4 flags lost overflow, underflow or end-value interrupt
// - counter byte bit 6 flags lost compare interrupt; odd bits read zero
// - bytes 10 and 11 hold input byte 1 lost flags on even bits
// - frequency record is four basic bytes plus twelve specific bytes
// - byte 4 bits 6 to 0 carry channel type 70h, digital input
// - byte 4 bit 7 says whether more channel types follow, here none
// - byte 5 reports eight diagnostic bits per channel
// - byte 6 reports eight channels per module
// - byte 7 bits 0 to 2 flag input channel group errors
// - byte 7 bit 3 flags group covering input byte 1 bits 4 to 7
// - frequency mode byte 7 bits 4 to 7 flag frequency meter groups
// - frequency bytes 12 to 15 bit 0 flag lost end of measurement
// - byte 0: bit 0 module failure, bit 2 external error, bit 3 channel error
// - byte 3 bit 6 set when an input interrupt, or a counter or frequency interrupt of the current mode, was lost
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module drcf_top
	import drcf_pkg::*;
#(
	parameter int ADDR_W    = 8,
	parameter int NUM_UNITS = 4,
	parameter int NUM_INPUT = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWrStb,
	input  wire logic              regRdStb,
	output logic      [31:0]       regRdData,
	output logic                   irq,
	input  wire logic [15:0]       inputEvent,
	input  wire logic [15:0]       counterEvent,
	input  wire logic [3:0]        freqEndEvent,
	input  wire logic [7:0]        groupError,
	input  wire logic              moduleFail,
	input  wire logic              externalError,
	output logic                   freqMode
);
	if (ADDR_W < DRCF_IDX_W + 2) begin : g_chk_addr
		$error("drcf_top: ADDR_W too small for the register map");
	end
	if (NUM_UNITS != 4) begin : g_chk_units
		$error("drcf_top: only four counter or measurement units are supported");
	end
	if (NUM_INPUT != 16) begin : g_chk_inputs
		$error("drcf_top: only sixteen process interrupt inputs are supported");
	end

	// register port decode
	logic [DRCF_IDX_W-1:0] regIdx;
	logic                  addrHigh;
	logic                  hitControl;
	logic                  hitLostClear;
	logic                  hitAckInFreq;
	logic                  hitAckCounters;
	logic                  hitIrqStatus;
	logic                  hitIrqMask;
	logic                  hitBasic;
	logic                  hitChanType;
	logic                  hitDiagBits;
	logic                  hitChanCount;
	logic                  hitGroupErr;
	logic                  hitLostLow;
	logic                  hitLostHigh;
	logic                  hitLostB1Lo;
	logic                  hitLostB1Hi;
	logic                  hitUnit0;
	logic                  hitUnit1;
	logic                  hitUnit2;
	logic                  hitUnit3;

	assign regIdx         = regAddr[DRCF_IDX_W+1:2];
	assign addrHigh       = (ADDR_W > DRCF_IDX_W + 2) ? |(regAddr >> (DRCF_IDX_W + 2)) : 1'b0;
	assign hitControl     = !addrHigh && regIdx == IDX_CONTROL;
	assign hitLostClear   = !addrHigh && regIdx == IDX_LOST_CLEAR;
	assign hitAckInFreq   = !addrHigh && regIdx == IDX_ACK_INPUTS_FREQ;
	assign hitAckCounters = !addrHigh && regIdx == IDX_ACK_COUNTERS;
	assign hitIrqStatus   = !addrHigh && regIdx == IDX_IRQ_STATUS;
	assign hitIrqMask     = !addrHigh && regIdx == IDX_IRQ_MASK;

	// record word decode
	assign hitBasic       = !addrHigh && regIdx == IDX_BASIC_DIAG_COPY;
	assign hitChanType    = !addrHigh && regIdx == IDX_CHANNEL_TYPE;
	assign hitDiagBits    = !addrHigh && regIdx == IDX_DIAG_BITS_PER_CH;
	assign hitChanCount   = !addrHigh && regIdx == IDX_CHANNEL_COUNT;
	assign hitGroupErr    = !addrHigh && regIdx == IDX_GROUP_ERRORS;
	assign hitLostLow     = !addrHigh && regIdx == IDX_LOST_INPUTS_LOW;
	assign hitLostHigh    = !addrHigh && regIdx == IDX_LOST_INPUTS_HIGH;
	assign hitLostB1Lo    = !addrHigh && regIdx == IDX_LOST_INPUTS_B1_LO;
	assign hitLostB1Hi    = !addrHigh && regIdx == IDX_LOST_INPUTS_B1_HI;
	assign hitUnit0       = !addrHigh && regIdx == IDX_UNIT0_LOST;
	assign hitUnit1       = !addrHigh && regIdx == IDX_UNIT1_LOST;
	assign hitUnit2       = !addrHigh && regIdx == IDX_UNIT2_LOST;
	assign hitUnit3       = !addrHigh && regIdx == IDX_UNIT3_LOST;

	// software controls
	logic             freqMode_q;
	logic             freqMode_d;
	logic [IRQ_W-1:0] irqMask_q;
	logic [IRQ_W-1:0] irqMask_d;
	logic             clearLost;
	logic [15:0]      ackInputs;
	logic [3:0]       ackFreq;
	logic [15:0]      ackCounters;

	assign freqMode_d  = (regWrStb && hitControl) ? regWrData[CTRL_BIT_FREQ_MODE] : freqMode_q;
	assign irqMask_d   = (regWrStb && hitIrqMask) ? regWrData[IRQ_W-1:0] : irqMask_q;
	assign clearLost   = regWrStb && hitLostClear && regWrData[CLR_BIT_LOST];
	assign ackInputs   = (regWrStb && hitAckInFreq) ? regWrData[15:0] : 16'h0000;
	assign ackFreq     = (regWrStb && hitAckInFreq) ? regWrData[ACK_FREQ_LSB+3:ACK_FREQ_LSB]
	                                                : 4'h0;
	assign ackCounters = (regWrStb && hitAckCounters) ? regWrData[15:0] : 16'h0000;

	// counter events only count in counter mode, end of measurement only in frequency mode
	logic [15:0] counterEventGated;
	logic [3:0]  freqEventGated;

	assign counterEventGated = freqMode_q ? 16'h0000 : counterEvent;
	assign freqEventGated    = freqMode_q ? freqEndEvent : 4'h0;

	// lost-interrupt tracking
	logic [15:0] inputPending;
	logic [15:0] inputLost;
	logic        inputNewLost;
	logic [15:0] counterPending;
	logic [15:0] counterLost;
	logic        counterNewLost;
	logic [3:0]  freqPending;
	logic [3:0]  freqLost;
	logic        freqNewLost;

	drcf_lost_flag #(
		.WIDTH(16)
	) u_input_lost (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.srcEvent (inputEvent),
		.ack      (ackInputs),
		.clearLost(clearLost),
		.pending  (inputPending),
		.lost     (inputLost),
		.newLost  (inputNewLost)
	);

	drcf_lost_flag #(
		.WIDTH(16)
	) u_counter_lost (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.srcEvent (counterEventGated),
		.ack      (ackCounters),
		.clearLost(clearLost),
		.pending  (counterPending),
		.lost     (counterLost),
		.newLost  (counterNewLost)
	);

	drcf_lost_flag #(
		.WIDTH(4)
	) u_freq_lost (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.srcEvent (freqEventGated),
		.ack      (ackFreq),
		.clearLost(clearLost),
		.pending  (freqPending),
		.lost     (freqLost),
		.newLost  (freqNewLost)
	);

	// flags on even bit positions, odd bits zero
	function automatic logic [7:0] spreadEven(input logic [3:0] v);
		spreadEven = {1'b0, v[3], 1'b0, v[2], 1'b0, v[1], 1'b0, v[0]};
	endfunction : spreadEven

	// basic record bytes 0 to 3
	logic       anyLost;
	logic       channelError;
	logic [7:0] recByte0;
	logic [7:0] recByte1;
	logic [7:0] recByte2;
	logic [7:0] recByte3;

	assign anyLost      = |inputLost || (!freqMode_q && |counterLost)
	                      || (freqMode_q && |freqLost);
	assign channelError = |groupError;
	assign recByte0     = {4'h0, channelError, externalError, 1'b0, moduleFail};
	assign recByte1     = {3'b000, CHAN_INFO_PRESENT, MODULE_CLASS_DIGITAL};
	assign recByte2     = 8'h00;
	assign recByte3     = {1'b0, anyLost, 6'b00_0000};

	// module specific bytes 4 to 11
	logic [7:0] recByte4;
	logic [7:0] recByte5;
	logic [7:0] recByte6;
	logic [7:0] recByte7;
	logic [7:0] recByte8;
	logic [7:0] recByte9;
	logic [7:0] recByte10;
	logic [7:0] recByte11;

	assign recByte4  = {MORE_TYPES_NONE, CHAN_TYPE_DIG_IN};
	assign recByte5  = DIAG_BITS_PER_CHANNEL;
	assign recByte6  = CHANNELS_PER_MODULE;
	// bits 3:0 input groups, bits 7:4 counters or frequency meters
	assign recByte7  = groupError;
	assign recByte8  = spreadEven(inputLost[3:0]);
	assign recByte9  = spreadEven(inputLost[7:4]);
	assign recByte10 = spreadEven(inputLost[11:8]);
	assign recByte11 = spreadEven(inputLost[15:12]);

	// bytes 12 to 15 per counter or per measurement channel
	logic [7:0] unitByte [NUM_UNITS];

	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
		logic [7:0] cntByte;
		logic [7:0] freqByte;
		always_comb begin
			cntByte = 8'h00;
			cntByte[CNT_BIT_GATE_CLOSED] = counterLost[u*4+KIND_GATE_CLOSED];
			cntByte[CNT_BIT_GATE_OPENED] = counterLost[u*4+KIND_GATE_OPENED];
			cntByte[CNT_BIT_OVERFLOW]    = counterLost[u*4+KIND_OVERFLOW];
			cntByte[CNT_BIT_COMPARE]     = counterLost[u*4+KIND_COMPARE];
		end
		assign freqByte    = {7'h00, freqLost[u]};
		assign unitByte[u] = freqMode_q ? freqByte : cntByte;
	end

	// interrupt status, cleared by reading it, events win over the clear
	logic [IRQ_W-1:0] irqStatus_q;
	logic [IRQ_W-1:0] irqStatus_d;
	logic [IRQ_W-1:0] irqEvent;
	logic             groupErrAny_q;
	logic             moduleFail_q;
	logic             irq_d;
	logic             statusRead;

	assign statusRead = regRdStb && hitIrqStatus;

	always_comb begin
		irqEvent = '0;
		irqEvent[IRQ_BIT_LOST]      = inputNewLost || counterNewLost || freqNewLost;
		irqEvent[IRQ_BIT_GROUP_ERR] = channelError && !groupErrAny_q;
		irqEvent[IRQ_BIT_MOD_FAIL]  = moduleFail && !moduleFail_q;
	end

	assign irqStatus_d = irqEvent | (irqStatus_q & {IRQ_W{~statusRead}});
	assign irq_d       = |(irqStatus_d & irqMask_d);

	// read multiplexer, sixteen record words then own registers
	logic [31:0] rdMux;
	logic [31:0] recWord;
	logic [31:0] ownWord;
	logic        rdRecord;

	assign rdRecord = !addrHigh && regIdx < IDX_CONTROL;

	// record words, bytes 4 to 15 sit in bits 7:0, gap words read zero
	always_comb begin
		recWord = 32'h0000_0000;
		if (hitBasic) begin
			recWord = {recByte3, recByte2, recByte1, recByte0};
		end else if (hitChanType) begin
			recWord = {24'h00_0000, recByte4};
		end else if (hitDiagBits) begin
			recWord = {24'h00_0000, recByte5};
		end else if (hitChanCount) begin
			recWord = {24'h00_0000, recByte6};
		end else if (hitGroupErr) begin
			recWord = {24'h00_0000, recByte7};
		end else if (hitLostLow) begin
			recWord = {24'h00_0000, recByte8};
		end else if (hitLostHigh) begin
			recWord = {24'h00_0000, recByte9};
		end else if (hitLostB1Lo) begin
			recWord = {24'h00_0000, recByte10};
		end else if (hitLostB1Hi) begin
			recWord = {24'h00_0000, recByte11};
		end else if (hitUnit0) begin
			recWord = {24'h00_0000, unitByte[0]};
		end else if (hitUnit1) begin
			recWord = {24'h00_0000, unitByte[1]};
		end else if (hitUnit2) begin
			recWord = {24'h00_0000, unitByte[2]};
		end else if (hitUnit3) begin
			recWord = {24'h00_0000, unitByte[3]};
		end
	end

	// own control, acknowledge and interrupt registers
	always_comb begin
		ownWord = 32'h0000_0000;
		if (hitControl) begin
			ownWord = {31'h0000_0000, freqMode_q};
		end else if (hitAckInFreq) begin
			ownWord = {12'h000, freqPending, inputPending};
		end else if (hitAckCounters) begin
			ownWord = {16'h0000, counterPending};
		end else if (hitIrqStatus) begin
			ownWord = {29'h0000_0000, irqStatus_q};
		end else if (hitIrqMask) begin
			ownWord = {29'h0000_0000, irqMask_q};
		end
	end

	assign rdMux = rdRecord ? recWord : ownWord;

	// state registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			freqMode_q    <= 1'b0;
			irqMask_q     <= '0;
			irqStatus_q   <= '0;
			groupErrAny_q <= 1'b0;
			moduleFail_q  <= 1'b0;
		end else begin
			freqMode_q    <= freqMode_d;
			irqMask_q     <= irqMask_d;
			irqStatus_q   <= irqStatus_d;
			groupErrAny_q <= channelError;
			moduleFail_q  <= moduleFail;
		end
	end

	// outputs straight from flip-flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			regRdData <= 32'h0000_0000;
			irq       <= 1'b0;
			freqMode  <= 1'b0;
		end else begin
			regRdData <= regRdStb ? rdMux : 32'h0000_0000;
			irq       <= irq_d;
			freqMode  <= freqMode_d;
		end
	end
endmodule : drcf_top

// ==== src/drcf_pkg.sv ====
// constants of the extended diagnostic record for counter and frequency modes
package drcf_pkg;
	localparam int DRCF_DATA_W          = 32;
	localparam int DRCF_IDX_W           = 6;
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_BASIC_DIAG_COPY   = 6'h00;
	localparam logic [5:0] IDX_CHANNEL_TYPE      = 6'h04;
	localparam logic [5:0] IDX_DIAG_BITS_PER_CH  = 6'h05;
	localparam logic [5:0] IDX_CHANNEL_COUNT     = 6'h06;
	localparam logic [5:0] IDX_GROUP_ERRORS      = 6'h07;
	localparam logic [5:0] IDX_LOST_INPUTS_LOW   = 6'h08;
	localparam logic [5:0] IDX_LOST_INPUTS_HIGH  = 6'h09;
	localparam logic [5:0] IDX_LOST_INPUTS_B1_LO = 6'h0a;
	localparam logic [5:0] IDX_LOST_INPUTS_B1_HI = 6'h0b;
	localparam logic [5:0] IDX_UNIT0_LOST        = 6'h0c;
	localparam logic [5:0] IDX_UNIT1_LOST        = 6'h0d;
	localparam logic [5:0] IDX_UNIT2_LOST        = 6'h0e;
	localparam logic [5:0] IDX_UNIT3_LOST        = 6'h0f;
	localparam logic [5:0] IDX_CONTROL           = 6'h10;
	localparam logic [5:0] IDX_LOST_CLEAR        = 6'h11;
	localparam logic [5:0] IDX_ACK_INPUTS_FREQ   = 6'h12;
	localparam logic [5:0] IDX_ACK_COUNTERS      = 6'h13;
	localparam logic [5:0] IDX_IRQ_STATUS        = 6'h14;
	localparam logic [5:0] IDX_IRQ_MASK          = 6'h15;
	// record content
	localparam logic [6:0] CHAN_TYPE_DIG_IN      = 7'h70;
	localparam logic       MORE_TYPES_NONE       = 1'b0;
	localparam logic [7:0] DIAG_BITS_PER_CHANNEL = 8'h08;
	localparam logic [7:0] CHANNELS_PER_MODULE   = 8'h08;
	localparam logic [3:0] MODULE_CLASS_DIGITAL  = 4'hf;
	localparam logic       CHAN_INFO_PRESENT     = 1'b1;
	// counter byte bit positions
	localparam int CNT_BIT_GATE_CLOSED = 0;
	localparam int CNT_BIT_GATE_OPENED = 2;
	localparam int CNT_BIT_OVERFLOW    = 4;
	localparam int CNT_BIT_COMPARE     = 6;
	// event kinds per counter, index counter*4+kind
	localparam int KIND_GATE_CLOSED = 0;
	localparam int KIND_GATE_OPENED = 1;
	localparam int KIND_OVERFLOW    = 2;
	localparam int KIND_COMPARE     = 3;
	// control and interrupt fields
	localparam int CTRL_BIT_FREQ_MODE = 0;
	localparam int CLR_BIT_LOST       = 0;
	localparam int IRQ_BIT_LOST       = 0;
	localparam int IRQ_BIT_GROUP_ERR  = 1;
	localparam int IRQ_BIT_MOD_FAIL   = 2;
	localparam int IRQ_W              = 3;
	localparam int ACK_FREQ_LSB       = 16;
endpackage : drcf_pkg

// ==== src/drcf_lost_flag.sv ====
// pending and lost-interrupt flags for a group of process interrupt sources
`timescale 1ns/10ps
module drcf_lost_flag #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] srcEvent,
	input  wire logic [WIDTH-1:0] ack,
	input  wire logic             clearLost,
	output logic      [WIDTH-1:0] pending,
	output logic      [WIDTH-1:0] lost,
	output logic                  newLost
);
	logic [WIDTH-1:0] pending_q;
	logic [WIDTH-1:0] pending_d;
	logic [WIDTH-1:0] lost_q;
	logic [WIDTH-1:0] lost_d;
	logic [WIDTH-1:0] lostSet;

	if (WIDTH < 1) begin : g_chk
		$error("drcf_lost_flag: WIDTH must be at least 1");
	end

	// an event meets an unaccepted one from the same source
	assign lostSet   = srcEvent & pending_q & ~ack;
	assign pending_d = srcEvent | (pending_q & ~ack);
	// set wins over clear
	assign lost_d    = lostSet | (lost_q & {WIDTH{~clearLost}});

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pending_q <= '0;
			lost_q    <= '0;
			newLost   <= 1'b0;
		end else begin
			pending_q <= pending_d;
			lost_q    <= lost_d;
			newLost   <= |lostSet;
		end
	end

	assign pending = pending_q;
	assign lost    = lost_q;
endmodule : drcf_lost_flag

// ==== bench/drcf_top_sva.sv ====
// assertion checker for the extended diagnostic record block
`timescale 1ns/10ps
module drcf_top_chk
	import drcf_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              sys_clk,
	input wire logic              srst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regRdStb,
	input wire logic [31:0]       regRdData,
	input wire logic [7:0]        groupError,
	input wire logic              moduleFail,
	input wire logic              externalError,
	input wire logic              freqMode
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	logic [5:0] idx;
	assign idx = regAddr[7:2];
	property p_rd_quiet;
		!regRdStb |=> regRdData == 32'h0000_0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero when idle");
	property p_type;
		regRdStb && idx == IDX_CHANNEL_TYPE |=>
			regRdData == {24'h00_0000, MORE_TYPES_NONE, CHAN_TYPE_DIG_IN};
	endproperty
	a_type: assert property (p_type) else $error("channel type byte wrong");
	property p_bits;
		regRdStb && idx == IDX_DIAG_BITS_PER_CH |=> regRdData == {24'h00_0000, 8'h08};
	endproperty
	a_bits: assert property (p_bits) else $error("bits per channel wrong");
	property p_chans;
		regRdStb && idx == IDX_CHANNEL_COUNT |=> regRdData == {24'h00_0000, 8'h08};
	endproperty
	a_chans: assert property (p_chans) else $error("channel count wrong");
	property p_group;
		regRdStb && idx == IDX_GROUP_ERRORS |=> regRdData == {24'h00_0000, $past(groupError)};
	endproperty
	a_group: assert property (p_group) else $error("group error byte wrong");
	property p_word0;
		regRdStb && idx == IDX_BASIC_DIAG_COPY |=> (regRdData & 32'hbfff_ffff) ==
			{16'h0000, 8'h1f, 4'h0, |$past(groupError), $past(externalError), 1'b0,
			$past(moduleFail)};
	endproperty
	a_word0: assert property (p_word0) else $error("basic record copy wrong");
	property p_unmapped;
		regRdStb && idx > 6'h00 && idx < 6'h04 |=> regRdData == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("gap word not zero");
	property p_cnt_odd;
		regRdStb && !freqMode && idx >= IDX_LOST_INPUTS_B1_LO && idx <= IDX_UNIT3_LOST |=>
			(regRdData & 32'hffff_ffaa) == 32'h0000_0000;
	endproperty
	a_cnt_odd: assert property (p_cnt_odd) else $error("odd lost bits set");
	property p_freq_unit;
		regRdStb && freqMode && idx >= IDX_UNIT0_LOST && idx <= IDX_UNIT3_LOST |=>
			regRdData[31:1] == 31'h0;
	endproperty
	a_freq_unit: assert property (p_freq_unit) else $error("frequency byte high bits set");
endmodule : drcf_top_chk
bind drcf_top drcf_top_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .srst(srst),
	.regAddr(regAddr), .regRdStb(regRdStb), .regRdData(regRdData), .groupError(groupError),
	.moduleFail(moduleFail), .externalError(externalError), .freqMode(freqMode));

// ==== bench/test_drcf_top.sv ====
// self-checking bench for the extended diagnostic record block
`timescale 1ns/10ps
module test_drcf_top
	import drcf_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic        regWrStb = 1'b0;
	logic        regRdStb = 1'b0;
	logic [31:0] regRdData;
	logic        irq;
	logic        freqMode;
	logic [15:0] inputEvent = 16'h0000;
	logic [15:0] counterEvent = 16'h0000;
	logic [3:0]  freqEndEvent = 4'h0;
	logic [7:0]  groupError = 8'h00;
	logic        moduleFail = 1'b0;
	logic        externalError = 1'b0;
	logic [31:0] expQ[$];
	logic        rdPend = 1'b0;
	logic [15:0] rnd;
	logic [7:0]  g = 8'h00;
	logic        mf = 1'b0;
	logic        ex = 1'b0;
	int          n_errors = 0;
	int          checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	drcf_top uut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq),
		.inputEvent(inputEvent), .counterEvent(counterEvent), .freqEndEvent(freqEndEvent),
		.groupError(groupError), .moduleFail(moduleFail), .externalError(externalError),
		.freqMode(freqMode));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp
	// level outputs are looked at mid-cycle, after the edge that launched them has settled
	task automatic cmpIrq(input logic exp, input string what);
		@(negedge sys_clk);
		cmp({31'h0, irq}, {31'h0, exp}, what);
		@(posedge sys_clk);
	endtask : cmpIrq
	task automatic cmpMode(input logic exp);
		@(negedge sys_clk);
		cmp({31'h0, freqMode}, {31'h0, exp}, "mode");
		@(posedge sys_clk);
	endtask : cmpMode
	// read results are compared against the oldest note in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rdPend && expQ.size() > 0) cmp(regRdData, expQ.pop_front(), "read");
		rdPend = regRdStb;
	end
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		regWrStb <= 1'b0;
		regRdStb <= 1'b1;
		regAddr  <= a;
		expQ.push_back(e);
		@(posedge sys_clk);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regRdStb  <= 1'b0;
		regWrStb  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge sys_clk);
	endtask : wr
	task automatic idle(input int n);
		regRdStb <= 1'b0;
		regWrStb <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle
	task automatic fire(input int which, input int b);
		regRdStb <= 1'b0;
		regWrStb <= 1'b0;
		case (which)
			0: inputEvent <= 16'h0001 << b;
			1: counterEvent <= 16'h0001 << b;
			default: freqEndEvent <= 4'h1 << b;
		endcase
		@(posedge sys_clk);
		inputEvent <= 16'h0000;
		counterEvent <= 16'h0000;
		freqEndEvent <= 4'h0;
		@(posedge sys_clk);
	endtask : fire
	// each source fires twice; a set rnd bit acknowledges in between
	task automatic lostRun(input int which, input int n, input logic [7:0] ackA, input int sh);
		for (int i = 0; i < n; i++) begin
			fire(which, i);
			if (rnd[i]) wr(ackA, 32'h0000_0001 << (i + sh));
			fire(which, i);
		end
		wr(ackA, 32'h000f_ffff);
		idle(1);
	endtask : lostRun
	function automatic logic [31:0] lostByte(input logic [3:0] v);
		return {24'h00_0000, 1'b0, v[3], 1'b0, v[2], 1'b0, v[1], 1'b0, v[0]};
	endfunction : lostByte
	function automatic logic [31:0] word0(input logic lost);
		return {1'b0, lost, 14'h0, 8'h1f, 4'h0, |g, ex, 1'b0, mf};
	endfunction : word0
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		#100000;
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		summarize();
	end
	initial begin
		void'($urandom(20));
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		wr(8'h10, 32'hffff_ffff);
		rd(8'h00, word0(1'b0));
		rd(8'h04, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0000);
		rd(8'h10, 32'h0000_0070);
		rd(8'h17, 32'h0000_0008);
		rd(8'h18, 32'h0000_0008);
		rd(8'h40, 32'h0000_0000);
		rd(8'h50, 32'h0000_0000);
		rd(8'h54, 32'h0000_0000);
		rd(8'h80, 32'h0000_0000);
		idle(2);
		$display("test reset_values finished");
		rnd = 16'($urandom()) & 16'hfffe;
		lostRun(0, 16, 8'h48, 0);
		for (int i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), lostByte(~rnd[4 * i +: 4]));
		rd(8'h48, 32'h0000_0000);
		rd(8'h00, word0(1'b1));
		idle(1);
		cmpIrq(1'b0, "irq masked");
		wr(8'h54, 32'h0000_0001);
		idle(2);
		cmpIrq(1'b1, "irq raised");
		rd(8'h50, 32'h0000_0001);
		idle(3);
		cmpIrq(1'b0, "irq cleared");
		wr(8'h44, 32'h0000_0001);
		rd(8'h28, 32'h0000_0000);
		idle(2);
		$display("test input_lost finished");
		rnd = 16'($urandom());
		lostRun(1, 16, 8'h4c, 0);
		for (int i = 0; i < 4; i++) rd(8'h30 + 8'(4 * i), lostByte(~rnd[4 * i +: 4]));
		rd(8'h00, word0(|(~rnd)));
		idle(2);
		$display("test counter_lost finished");
		wr(8'h40, 32'h0000_0001);
		idle(1);
		cmpMode(1'b1);
		rd(8'h30, 32'h0000_0000);
		rd(8'h00, word0(1'b0));
		rnd = 16'($urandom()) & 16'hfffe;
		lostRun(2, 4, 8'h48, ACK_FREQ_LSB);
		for (int i = 0; i < 4; i++) rd(8'h30 + 8'(4 * i), {31'h0, ~rnd[i]});
		rd(8'h00, word0(1'b1));
		idle(2);
		$display("test freq_lost finished");
		fire(1, 0);
		fire(1, 0);
		rd(8'h4c, 32'h0000_0000);
		rd(8'h50, 32'h0000_0001);
		groupError <= 8'h10;
		moduleFail <= 1'b1;
		idle(2);
		rd(8'h50, 32'h0000_0006);
		idle(1);
		cmpIrq(1'b0, "irq masked sources");
		$display("test irq_sources finished");
		repeat (8) begin
			g = 8'($urandom());
			mf = 1'($urandom());
			ex = 1'($urandom());
			groupError <= g;
			moduleFail <= mf;
			externalError <= ex;
			idle(1);
			rd(8'h00, word0(1'b1));
			rd(8'h1c, {24'h00_0000, g});
		end
		idle(3);
		$display("test record_random finished");
		summarize();
	end
endmodule : test_drcf_top
